// *** rtl/lbs_pkg.sv ***
package lbs_pkg;
    // protected word layout: 32 data bits, 6 hamming bits, 1 overall parity bit
    localparam int DW     = 32;
    localparam int CW     = 39;
    localparam int SYN_W  = 6;

    localparam int NSLOT     = 4;
    localparam int SLOT_W    = 2;
    localparam int CODE_SETS = 128;
    localparam int CODE_AW   = 7;
    localparam int STT_AW    = 6;
    localparam int OPS_W     = 12;
    localparam int LEN_W     = 16;

    // code parameter word fields
    localparam int SZ_LSB = 0;
    localparam int SZ_W   = 10;
    localparam int MS_LSB = 10;
    localparam int MS_W   = 2;
    localparam int NP_BIT = 12;
    localparam int LC_LSB = 13;
    localparam int LC_W   = 7;
    localparam int XC_LSB = 20;
    localparam int XC_W   = 4;
    localparam int SO_LSB = 24;
    localparam int SO_W   = 6;

    // layer stall table word fields
    localparam int ST_LSB = 0;
    localparam int ST_W   = 8;

    // control beat: code id then packet length in beats
    localparam int CT_ID_LSB  = 0;
    localparam int CT_LEN_LSB = 7;
    localparam int CTRL_W     = 23;

    localparam logic [SZ_W-1:0] PACK_MAX   = 10'h040;
    localparam int              NPROC_LOG  = 7;
    localparam logic [2:0]      MAX_BLOCKS = 3'h4;
    localparam logic [3:0]      ECC_RST    = 4'h0;

    typedef enum logic [2:0] {
        ADM_IDLE  = 3'b000,
        ADM_RDCPM = 3'b001,
        ADM_RDSTT = 3'b011,
        ADM_CHECK = 3'b010,
        ADM_INPUT = 3'b110
    } lbs_adm_t;

    function automatic logic [CW-1:0] secded_enc(input logic [DW-1:0] d);
        logic [CW-1:0] c;
        int            k;
        c = '0;
        k = 0;
        for (int p = 1; p < CW; p++) begin
            if ((p & (p - 1)) != 0) begin
                c[p] = d[k];
                k++;
            end
        end
        for (int i = 0; i < SYN_W; i++) begin
            for (int p = 1; p < CW; p++) begin
                if (p[i] && p != (1 << i)) begin
                    c[1 << i] = c[1 << i] ^ c[p];
                end
            end
        end
        c[0] = ^c[CW-1:1];
        return c;
    endfunction
endpackage

// *** rtl/lbs_ecc_if.sv ***
`timescale 1ns/100ps
`default_nettype none
interface lbs_ecc_if;
    logic [lbs_pkg::CW-1:0] cw;
    logic [lbs_pkg::DW-1:0] data;
    logic                   err;
    logic                   dbl;
    modport mem (output cw, input data, input err, input dbl);
    modport dec (input cw, output data, output err, output dbl);
endinterface
`default_nettype wire

// *** rtl/lbs_secded_dec.sv ***
`timescale 1ns/100ps
`default_nettype none
module lbs_secded_dec (
    lbs_ecc_if.dec port
);
    logic [lbs_pkg::SYN_W-1:0] syn;
    logic                      par;
    logic [lbs_pkg::CW-1:0]    fixed;
    logic                      bad_pos;
    int                        k;

    always_comb begin
        syn = '0;
        k   = 0;
        for (int p = 1; p < lbs_pkg::CW; p++) begin
            if (port.cw[p]) begin
                syn = syn ^ lbs_pkg::SYN_W'(p);
            end
        end
        par     = ^port.cw;
        bad_pos = int'(syn) >= lbs_pkg::CW;
        fixed   = port.cw;
        // odd parity with a valid syndrome: one flipped bit, put it back
        if (par && !bad_pos) begin
            fixed[syn] = ~fixed[syn];
        end
        port.data = '0;
        for (int p = 1; p < lbs_pkg::CW; p++) begin
            if ((p & (p - 1)) != 0) begin
                port.data[k] = fixed[p];
                k++;
            end
        end
        port.err = (syn != '0) || par;
        port.dbl = ((syn != '0) && !par) || (par && bad_pos);
    end
endmodule
`default_nettype wire

// *** rtl/lbs_sched_stream.sv ***
`timescale 1ns/100ps
`default_nettype none
module lbs_sched_stream #(
    parameter int NPROC   = 128,
    parameter int MEM_CAP = 4096
) (
    input  wire logic                            I_CLK_SYS,
    input  wire logic                            I_RESET,
    input  wire logic                            i_CPM_WE,
    input  wire logic [lbs_pkg::CODE_AW-1:0]     i_CPM_ADDR,
    input  wire logic [lbs_pkg::DW-1:0]          i_CPM_WDATA,
    input  wire logic                            i_STT_WE,
    input  wire logic [lbs_pkg::STT_AW-1:0]      i_STT_ADDR,
    input  wire logic [lbs_pkg::DW-1:0]          i_STT_WDATA,
    input  wire logic [lbs_pkg::CW-1:0]          i_ECC_FLIP,
    input  wire logic                            i_CTRL_TVALID,
    input  wire logic [lbs_pkg::CTRL_W-1:0]      i_CTRL_TDATA,
    output logic                                 o_CTRL_TREADY,
    input  wire logic                            i_DIN_TVALID,
    input  wire logic                            i_DIN_TLAST,
    output logic                                 o_DIN_TREADY,
    output logic                                 o_DOUT_TVALID,
    output logic                                 o_DOUT_TLAST,
    output logic [lbs_pkg::SLOT_W-1:0]           o_DOUT_TUSER,
    input  wire logic                            i_DOUT_TREADY,
    output logic                                 o_TLAST_UNEXP,
    output logic                                 o_TLAST_MISS,
    output logic [3:0]                           o_ECC_STATUS,
    output logic [2:0]                           o_ACTIVE_BLOCKS,
    output logic                                 o_ENGINE_IDLE
);
    localparam int NS = lbs_pkg::NSLOT;
    localparam int SW = lbs_pkg::SLOT_W;
    localparam int LW = lbs_pkg::LEN_W;
    localparam int OW = lbs_pkg::OPS_W;

    // protected memories: code parameter sets and shared layer stall table
    logic [lbs_pkg::CW-1:0] cpm_mem [lbs_pkg::CODE_SETS];
    logic [lbs_pkg::CW-1:0] stt_mem [2**lbs_pkg::STT_AW];

    lbs_ecc_if cpm_if ();
    lbs_ecc_if stt_if ();
    lbs_secded_dec u_cpm_dec (.port(cpm_if));
    lbs_secded_dec u_stt_dec (.port(stt_if));

    lbs_pkg::lbs_adm_t      adm_q;
    logic [lbs_pkg::CW-1:0] cpm_cw_q;
    logic [lbs_pkg::CW-1:0] stt_cw_q;
    logic [lbs_pkg::DW-1:0] par_q;
    logic [lbs_pkg::ST_W-1:0] stall_q;
    logic [LW-1:0]          len_q;
    logic [LW-1:0]          beat_q;
    logic                   ctrl_rdy_q;
    logic                   din_rdy_q;
    logic                   idle_seen_q;
    logic [15:0]            mem_used_q;
    logic [SW-1:0]          rr_q;

    // per-slot state
    // unpacked so that each slot process owns its own element
    logic                   busy_q  [NS];
    logic                   done_q  [NS];
    logic [OW-1:0]          ops_q   [NS];
    logic [lbs_pkg::ST_W-1:0] stc_q [NS];
    logic [lbs_pkg::ST_W-1:0] stv_q [NS];
    logic [LW-1:0]          slen_q  [NS];
    logic [2:0]             slim_q  [NS];

    logic                   out_busy_q;
    logic                   out_last_q;
    logic [SW-1:0]          out_idx_q;
    logic [LW-1:0]          out_rem_q;

    logic                   ctrl_take;
    logic                   din_take;
    logic                   din_last;
    logic                   alloc;
    logic                   out_take;
    logic                   out_free;
    logic                   out_load;
    logic                   admit_ok;
    logic [2:0]             act_cnt;
    logic [2:0]             lim_min;
    logic [2:0]             new_lim;
    logic                   have_free;
    logic [SW-1:0]          free_idx;
    logic                   eng_hit;
    logic [SW-1:0]          eng_idx;
    logic                   any_dec;
    logic                   done_hit;
    logic [SW-1:0]          done_idx;
    logic [SW-1:0]          j;
    logic [OW-1:0]          new_ops;
    logic [4:0]             per_layer;
    logic [lbs_pkg::LC_W-1:0] eff_layers;
    logic                   packed_blk;
    logic [SW-1:0]          fj;

    wire logic [lbs_pkg::SZ_W-1:0] p_size = par_q[lbs_pkg::SZ_LSB +: lbs_pkg::SZ_W];
    wire logic [lbs_pkg::MS_W-1:0] p_ms   = par_q[lbs_pkg::MS_LSB +: lbs_pkg::MS_W];
    wire logic [lbs_pkg::LC_W-1:0] p_lc   = par_q[lbs_pkg::LC_LSB +: lbs_pkg::LC_W];
    wire logic [lbs_pkg::XC_W-1:0] p_xc   = par_q[lbs_pkg::XC_LSB +: lbs_pkg::XC_W];

    assign cpm_if.cw = cpm_cw_q;
    assign stt_if.cw = stt_cw_q;

    // handshakes count only on both levels high in the same cycle
    assign ctrl_take = i_CTRL_TVALID && ctrl_rdy_q;
    assign din_take  = i_DIN_TVALID && din_rdy_q;
    assign out_take  = out_busy_q && i_DOUT_TREADY;
    assign din_last  = (beat_q == len_q - LW'(1));
    assign alloc     = din_take && din_last;
    assign out_free  = out_take && out_last_q;
    assign out_load  = !out_busy_q && done_hit;

    always_comb begin
        act_cnt   = '0;
        lim_min   = lbs_pkg::MAX_BLOCKS;
        have_free = 1'b0;
        free_idx  = '0;
        eng_hit   = 1'b0;
        eng_idx   = '0;
        any_dec   = 1'b0;
        done_hit  = 1'b0;
        done_idx  = '0;
        j         = '0;
        fj        = '0;
        for (int i = 0; i < NS; i++) begin
            fj = SW'(NS - 1 - i);
            if (busy_q[i]) begin
                act_cnt = act_cnt + 3'h1;
                if (slim_q[i] < lim_min) begin
                    lim_min = slim_q[i];
                end
            end else begin
                have_free = 1'b1;
            end
            if (!busy_q[fj]) begin
                free_idx = fj;
            end
            if (busy_q[fj] && done_q[fj] && !(out_busy_q && out_idx_q == fj)) begin
                done_hit = 1'b1;
                done_idx = fj;
            end
            j = rr_q + SW'(NS - 1 - i);
            if (busy_q[j] && !done_q[j]) begin
                any_dec = 1'b1;
                if (stc_q[j] == '0) begin
                    eng_hit = 1'b1;
                    eng_idx = j;
                end
            end
        end
    end

    // zero means no limit beyond the four-block maximum
    assign new_lim  = (p_ms == '0) ? lbs_pkg::MAX_BLOCKS : {1'b0, p_ms};
    assign admit_ok = (act_cnt == '0) ||
                      (idle_seen_q && have_free &&
                       (act_cnt + 3'h1 <= lim_min) && (act_cnt + 3'h1 <= new_lim) &&
                       (32'(mem_used_q) + 32'(len_q) <= MEM_CAP));

    // operation count per block: layers times (passes per submatrix plus extra circulants)
    always_comb begin
        packed_blk = (p_size <= lbs_pkg::PACK_MAX) && !par_q[lbs_pkg::NP_BIT];
        per_layer  = packed_blk ? 5'h1 :
                     5'((32'(p_size) + NPROC - 1) >> $clog2(NPROC));
        per_layer  = per_layer + 5'(p_xc);
        eff_layers = packed_blk ? lbs_pkg::LC_W'((8'(p_lc) + 8'h1) >> 1) : p_lc;
        new_ops    = OW'(eff_layers) * OW'(per_layer);
        if (new_ops == '0) begin
            new_ops = OW'(1);
        end
    end

    always_ff @(posedge I_CLK_SYS) begin
        if (i_CPM_WE) begin
            cpm_mem[i_CPM_ADDR] <= lbs_pkg::secded_enc(i_CPM_WDATA) ^ i_ECC_FLIP;
        end
        if (i_STT_WE) begin
            stt_mem[i_STT_ADDR] <= lbs_pkg::secded_enc(i_STT_WDATA) ^ i_ECC_FLIP;
        end
    end

    // admission: read code set, then its stall entry, then take the input packet
    always_ff @(posedge I_CLK_SYS) begin
        if (I_RESET) begin
            adm_q     <= lbs_pkg::ADM_IDLE;
            cpm_cw_q  <= '0;
            stt_cw_q  <= '0;
            par_q     <= '0;
            stall_q   <= '0;
            len_q     <= '0;
            beat_q    <= '0;
            din_rdy_q <= 1'b0;
        end else begin
            case (adm_q)
                lbs_pkg::ADM_IDLE: begin
                    if (ctrl_take) begin
                        cpm_cw_q <= cpm_mem[i_CTRL_TDATA[lbs_pkg::CT_ID_LSB +: lbs_pkg::CODE_AW]];
                        len_q    <= (i_CTRL_TDATA[lbs_pkg::CT_LEN_LSB +: LW] == '0) ? LW'(1) :
                                    i_CTRL_TDATA[lbs_pkg::CT_LEN_LSB +: LW];
                        adm_q    <= lbs_pkg::ADM_RDCPM;
                    end
                end
                lbs_pkg::ADM_RDCPM: begin
                    par_q    <= cpm_if.data;
                    stt_cw_q <= stt_mem[cpm_if.data[lbs_pkg::SO_LSB +: lbs_pkg::SO_W]];
                    adm_q    <= lbs_pkg::ADM_RDSTT;
                end
                lbs_pkg::ADM_RDSTT: begin
                    stall_q <= stt_if.data[lbs_pkg::ST_LSB +: lbs_pkg::ST_W];
                    adm_q   <= lbs_pkg::ADM_CHECK;
                end
                lbs_pkg::ADM_CHECK: begin
                    if (admit_ok) begin
                        beat_q    <= '0;
                        din_rdy_q <= 1'b1;
                        adm_q     <= lbs_pkg::ADM_INPUT;
                    end
                end
                lbs_pkg::ADM_INPUT: begin
                    if (din_take) begin
                        beat_q <= beat_q + LW'(1);
                        if (din_last) begin
                            din_rdy_q <= 1'b0;
                            adm_q     <= lbs_pkg::ADM_IDLE;
                        end
                    end
                end
                default: begin
                    din_rdy_q <= 1'b0;
                    adm_q     <= lbs_pkg::ADM_IDLE;
                end
            endcase
        end
    end

    // control ready is a registered level, dropped the cycle after each handshake on tvalid
    always_ff @(posedge I_CLK_SYS) begin
        if (I_RESET) begin
            ctrl_rdy_q <= 1'b0;
        end else begin
            ctrl_rdy_q <= (adm_q == lbs_pkg::ADM_IDLE) && !ctrl_take && have_free;
        end
    end

    // tlast is only reported, framing stays on the control length
    always_ff @(posedge I_CLK_SYS) begin
        if (I_RESET) begin
            o_TLAST_UNEXP <= 1'b0;
            o_TLAST_MISS  <= 1'b0;
        end else begin
            o_TLAST_UNEXP <= din_take && i_DIN_TLAST && !din_last;
            o_TLAST_MISS  <= din_take && !i_DIN_TLAST && din_last;
        end
    end

    // flags follow the most recent word read from each memory
    always_ff @(posedge I_CLK_SYS) begin
        if (I_RESET) begin
            o_ECC_STATUS <= lbs_pkg::ECC_RST;
        end else begin
            if (adm_q == lbs_pkg::ADM_RDCPM) begin
                o_ECC_STATUS[0] <= cpm_if.err;
                o_ECC_STATUS[1] <= cpm_if.dbl;
            end
            if (adm_q == lbs_pkg::ADM_RDSTT) begin
                o_ECC_STATUS[2] <= stt_if.err;
                o_ECC_STATUS[3] <= stt_if.dbl;
            end
        end
    end

    // idle engine cycles open the door for one more block
    always_ff @(posedge I_CLK_SYS) begin
        if (I_RESET) begin
            idle_seen_q   <= 1'b0;
            rr_q          <= '0;
            mem_used_q    <= '0;
            o_ENGINE_IDLE <= 1'b0;
            o_ACTIVE_BLOCKS <= '0;
        end else begin
            if (any_dec && !eng_hit) begin
                idle_seen_q <= 1'b1;
            end else if (alloc) begin
                idle_seen_q <= 1'b0;
            end
            if (eng_hit) begin
                rr_q <= eng_idx + SW'(1);
            end
            mem_used_q      <= mem_used_q + (alloc ? len_q : 16'h0000) -
                               (out_free ? slen_q[out_idx_q] : 16'h0000);
            o_ENGINE_IDLE   <= any_dec && !eng_hit;
            o_ACTIVE_BLOCKS <= act_cnt;
        end
    end

    generate
        for (genvar s = 0; s < NS; s++) begin : g_slot
            always_ff @(posedge I_CLK_SYS) begin
                if (I_RESET) begin
                    busy_q[s] <= 1'b0;
                    done_q[s] <= 1'b0;
                    ops_q[s]  <= '0;
                    stc_q[s]  <= '0;
                    stv_q[s]  <= '0;
                    slen_q[s] <= '0;
                    slim_q[s] <= lbs_pkg::MAX_BLOCKS;
                end else if (alloc && free_idx == SW'(s)) begin
                    busy_q[s] <= 1'b1;
                    done_q[s] <= 1'b0;
                    ops_q[s]  <= new_ops;
                    stc_q[s]  <= '0;
                    stv_q[s]  <= stall_q;
                    slen_q[s] <= len_q;
                    slim_q[s] <= new_lim;
                end else if (out_free && out_idx_q == SW'(s)) begin
                    busy_q[s] <= 1'b0;
                    done_q[s] <= 1'b0;
                end else if (busy_q[s] && !done_q[s]) begin
                    if (eng_hit && eng_idx == SW'(s)) begin
                        ops_q[s] <= ops_q[s] - OW'(1);
                        stc_q[s] <= stv_q[s];
                        if (ops_q[s] == OW'(1)) begin
                            done_q[s] <= 1'b1;
                        end
                    end else if (stc_q[s] != '0) begin
                        stc_q[s] <= stc_q[s] - lbs_pkg::ST_W'(1);
                    end
                end
            end
        end
    endgenerate

    // output stream: one finished block at a time, tlast on its final beat
    always_ff @(posedge I_CLK_SYS) begin
        if (I_RESET) begin
            out_busy_q <= 1'b0;
            out_last_q <= 1'b0;
            out_idx_q  <= '0;
            out_rem_q  <= '0;
        end else if (out_load) begin
            out_busy_q <= 1'b1;
            out_idx_q  <= done_idx;
            out_rem_q  <= slen_q[done_idx];
            out_last_q <= (slen_q[done_idx] == LW'(1));
        end else if (out_take) begin
            if (out_last_q) begin
                out_busy_q <= 1'b0;
                out_last_q <= 1'b0;
            end else begin
                out_rem_q  <= out_rem_q - LW'(1);
                out_last_q <= (out_rem_q == LW'(2));
            end
        end
    end

    assign o_DIN_TREADY  = din_rdy_q;
    assign o_CTRL_TREADY = ctrl_rdy_q;
    assign o_DOUT_TVALID = out_busy_q;
    assign o_DOUT_TLAST  = out_last_q;
    assign o_DOUT_TUSER  = out_idx_q;
endmodule
`default_nettype wire

// *** testbench/lbs_props.sv ***
`timescale 1ns/100ps
`default_nettype none
module lbs_props (
    input wire logic       I_CLK_SYS,
    input wire logic       I_RESET,
    input wire logic       i_CTRL_TVALID,
    input wire logic       o_CTRL_TREADY,
    input wire logic       i_DIN_TVALID,
    input wire logic       i_DIN_TLAST,
    input wire logic       o_DIN_TREADY,
    input wire logic       o_DOUT_TVALID,
    input wire logic       o_DOUT_TLAST,
    input wire logic       i_DOUT_TREADY,
    input wire logic       o_TLAST_UNEXP,
    input wire logic       o_TLAST_MISS,
    input wire logic [2:0] o_ACTIVE_BLOCKS
);
    default clocking @(posedge I_CLK_SYS); endclocking
    default disable iff (I_RESET);
    sequence s_ctl; i_CTRL_TVALID && o_CTRL_TREADY; endsequence
    sequence s_din; i_DIN_TVALID && o_DIN_TREADY; endsequence
    sequence s_out; o_DOUT_TVALID && i_DOUT_TREADY; endsequence
    AST_CTRL_DROP: assert property (s_ctl |=> !o_CTRL_TREADY) else $error("ctrl ready held");
    AST_ADMIT_LAT: assert property (s_ctl |=> !o_DIN_TREADY [*3]) else $error("admitted early");
    AST_OUT_HOLD: assert property (o_DOUT_TVALID && !i_DOUT_TREADY |=> o_DOUT_TVALID && $stable(o_DOUT_TLAST))
        else $error("output beat dropped");
    AST_OUT_GAP: assert property (s_out ##0 o_DOUT_TLAST |=> !o_DOUT_TVALID) else $error("no gap");
    AST_UNEXP: assert property (o_TLAST_UNEXP |-> $past(i_DIN_TVALID && o_DIN_TREADY && i_DIN_TLAST)
        && o_DIN_TREADY) else $error("bad early tlast event");
    AST_MISS: assert property (o_TLAST_MISS |-> $past(i_DIN_TVALID && o_DIN_TREADY && !i_DIN_TLAST)
        && !o_DIN_TREADY) else $error("bad missing tlast event");
    AST_EV_EXCL: assert property (!(o_TLAST_UNEXP && o_TLAST_MISS)) else $error("both events");
    AST_BLK_MAX: assert property (o_ACTIVE_BLOCKS <= 3'h4) else $error("too many blocks");
    AST_ONE_ADM: assert property (s_din |-> !o_CTRL_TREADY) else $error("ctrl open in input");
endmodule
bind lbs_sched_stream lbs_props u_props (.I_CLK_SYS, .I_RESET, .i_CTRL_TVALID, .o_CTRL_TREADY,
    .i_DIN_TVALID, .i_DIN_TLAST, .o_DIN_TREADY, .o_DOUT_TVALID, .o_DOUT_TLAST, .i_DOUT_TREADY,
    .o_TLAST_UNEXP, .o_TLAST_MISS, .o_ACTIVE_BLOCKS);
`default_nettype wire

// *** testbench/lbs_sink.sv ***
`timescale 1ns/100ps
`default_nettype none
module lbs_sink (
    input  wire logic I_CLK_SYS,
    input  wire logic i_stall,
    input  wire logic i_valid,
    input  wire logic i_last,
    output logic      o_ready,
    output int        o_beats,
    output int        o_pkts,
    output int        o_plen
);
    int run;
    // ready follows the stall request only, never tvalid
    assign o_ready = !i_stall;
    always @(posedge I_CLK_SYS) begin
        if (i_valid && o_ready) begin
            o_beats <= o_beats + 1;
            run     <= i_last ? 0 : run + 1;
            if (i_last) begin
                o_pkts <= o_pkts + 1;
                o_plen <= run + 1;
            end
        end
    end
endmodule
`default_nettype wire

// *** testbench/tb_top.sv ***
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    logic                        clk, rst, cwe, swe, cv, dv, dl, stall, crdy, drdy, ov, ol, ordy, unexp, miss, idle;
    logic [lbs_pkg::CODE_AW-1:0] ca;
    logic [lbs_pkg::STT_AW-1:0]  sa;
    logic [lbs_pkg::DW-1:0]      cd, sd;
    logic [lbs_pkg::CW-1:0]      flip;
    logic [lbs_pkg::CTRL_W-1:0]  ct;
    logic [3:0]                  ecc;
    logic [2:0]                  act;
    logic [1:0]                  user;
    int                          miscompares, checks_done, n_unexp, n_miss, n_idle, beats, pkts, plen;
    lbs_sched_stream #(.MEM_CAP(16)) DUT (.I_CLK_SYS(clk), .I_RESET(rst), .i_CPM_WE(cwe), .i_CPM_ADDR(ca),
        .i_CPM_WDATA(cd), .i_STT_WE(swe), .i_STT_ADDR(sa), .i_STT_WDATA(sd), .i_ECC_FLIP(flip),
        .i_CTRL_TVALID(cv), .i_CTRL_TDATA(ct), .o_CTRL_TREADY(crdy), .i_DIN_TVALID(dv), .i_DIN_TLAST(dl),
        .o_DIN_TREADY(drdy), .o_DOUT_TVALID(ov), .o_DOUT_TLAST(ol), .o_DOUT_TUSER(user), .i_DOUT_TREADY(ordy),
        .o_TLAST_UNEXP(unexp), .o_TLAST_MISS(miss), .o_ECC_STATUS(ecc), .o_ACTIVE_BLOCKS(act),
        .o_ENGINE_IDLE(idle));
    lbs_sink u_sink (.I_CLK_SYS(clk), .i_stall(stall), .i_valid(ov), .i_last(ol), .o_ready(ordy),
        .o_beats(beats), .o_pkts(pkts), .o_plen(plen));
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    always @(posedge clk) begin
        if (unexp === 1'b1) n_unexp <= n_unexp + 1;
        if (miss === 1'b1) n_miss <= n_miss + 1;
        if (idle === 1'b1) n_idle <= n_idle + 1;
    end
    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic finish_test;
        $display("checks %0d mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    function automatic logic [31:0] cw(input logic [9:0] sz, input logic [1:0] lim, input logic [6:0] lc,
                                       input logic [5:0] so);
        return {2'h0, so, 4'h0, lc, 1'b0, lim, sz};
    endfunction
    task automatic wr(input logic s, input logic [6:0] a, input logic [31:0] d, input logic [38:0] f);
        @(posedge clk);
        cwe  <= !s;
        swe  <= s;
        ca   <= a;
        sa   <= a[5:0];
        cd   <= d;
        sd   <= d;
        flip <= f;
        @(posedge clk);
        cwe  <= 1'b0;
        swe  <= 1'b0;
        flip <= '0;
    endtask
    task automatic ctrl(input logic [6:0] id, input logic [15:0] len);
        int i;
        @(posedge clk);
        cv <= 1'b1;
        ct <= {len, id};
        i = 0;
        do begin @(negedge clk); i++; end while (crdy !== 1'b1 && i < 1000);
        check("ctrl ready", crdy, 1'b1);
        @(posedge clk);
        cv <= 1'b0;
    endtask
    // beats follow each other back to back; tlast pattern is chosen by the caller
    task automatic din(input int len, input logic early, input logic last_ok);
        int i;
        for (int k = 0; k < len; k++) begin
            dv <= 1'b1;
            dl <= (k == 0 && early) || (k == len - 1 && last_ok);
            i = 0;
            do begin @(negedge clk); i++; end while (drdy !== 1'b1 && i < 1000);
            check("din ready", drdy, 1'b1);
            @(posedge clk);
        end
        dv <= 1'b0;
    endtask
    task automatic drain(input int np);
        int i;
        i = 0;
        while (pkts < np && i < 3000) begin @(negedge clk); i++; end
        check("packets", pkts, np);
    endtask
    task automatic t_reset;
        @(negedge clk);
        check("ecc", ecc, 4'h0);
        check("active", act, 3'h0);
        @(negedge clk);
        check("ctrl ready", crdy, 1'b1);
        $display("test reset done");
    endtask
    task automatic t_tlast;
        ctrl(7'h00, 16'h0002);
        din(2, 1'b1, 1'b0);
        drain(pkts + 1);
        check("unexp", n_unexp, 1);
        check("miss", n_miss, 1);
        check("out len", plen, 2);
        check("slot", user, 2'h0);
        ctrl(7'h00, 16'h0001);
        din(1, 1'b0, 1'b1);
        drain(pkts + 1);
        check("events", n_unexp + n_miss, 2);
        $display("test tlast done");
    endtask
    task automatic t_ecc;
        logic [3:0] exp [4] = '{4'h1, 4'h3, 4'h4, 4'h0};
        for (int k = 0; k < 4; k++) begin
            ctrl(k == 3 ? 7'h00 : 7'(k + 2), 16'h0001);
            din(1, 1'b0, 1'b1);
            drain(pkts + 1);
            check("ecc", ecc, exp[k]);
            check("out len", plen, 1);
        end
        $display("test ecc done");
    endtask
    task automatic t_sched;
        int i;
        int p0;
        p0 = pkts;
        @(posedge clk);
        stall <= 1'b1;
        ctrl(7'h05, 16'h0008);
        din(8, 1'b0, 1'b1);
        // seven beats keep memory below the cap, so only the limit can refuse the next block
        ctrl(7'h05, 16'h0007);
        din(7, 1'b0, 1'b1);
        repeat (2) @(negedge clk);
        check("active", act, 3'h2);
        check("idle seen", n_idle > 0, 1'b1);
        ctrl(7'h01, 16'h0001);
        i = 0;
        repeat (60) begin @(negedge clk); i += int'(drdy === 1'b1); end
        check("refused", i, 0);
        @(posedge clk);
        stall <= 1'b0;
        din(1, 1'b0, 1'b1);
        drain(p0 + 3);
        $display("test sched done");
    endtask
    initial begin
        {rst, cwe, swe, cv, dv, dl, stall} = 7'h40;
        {ca, sa, cd, sd, flip, ct} = '0;
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        t_reset();
        wr(1'b1, 7'h00, 32'h0000_0000, '0);
        wr(1'b1, 7'h01, 32'h0000_0020, '0);
        wr(1'b1, 7'h02, 32'h0000_0000, 39'h200);
        wr(1'b0, 7'h00, cw(10'h080, 2'h0, 7'h01, 6'h00), '0);
        wr(1'b0, 7'h01, cw(10'h080, 2'h1, 7'h04, 6'h01), '0);
        wr(1'b0, 7'h02, cw(10'h080, 2'h0, 7'h01, 6'h00), 39'h20);
        wr(1'b0, 7'h03, cw(10'h080, 2'h0, 7'h01, 6'h00), 39'h28);
        wr(1'b0, 7'h04, cw(10'h080, 2'h0, 7'h01, 6'h02), '0);
        wr(1'b0, 7'h05, cw(10'h080, 2'h0, 7'h04, 6'h01), '0);
        t_tlast();
        t_ecc();
        t_sched();
        finish_test();
    end
    initial begin
        repeat (20000) @(posedge clk);
        miscompares++;
        finish_test();
    end
endmodule
`default_nettype wire
